//--- verilog/ctsc_pkg.sv
// package for the camera trigger and light strobe controller
package ctsc_pkg;
	localparam int TW = 24;
	typedef logic [TW-1:0] ctsc_time_type;

	typedef enum logic [1:0] {
		CTSC_NO_CONTROL = 2'b00,
		CTSC_RATE_ONLY  = 2'b01,
		CTSC_RATE_WIDTH = 2'b10,
		CTSC_EXTERNAL   = 2'b11
	} ctsc_method_type;

	typedef enum logic [1:0] {
		CTSC_IDLE  = 2'b00,
		CTSC_PRE   = 2'b01,
		CTSC_RUN   = 2'b10,
		CTSC_GUARD = 2'b11
	} ctsc_state_type;

	typedef struct packed {
		ctsc_method_type method;
		logic            early_light;
		logic            overlap_ok;
		ctsc_time_type   trigger_pulse_width;
		ctsc_time_type   light_pulse_width;
		ctsc_time_type   light_pulse_offset;
		ctsc_time_type   readout_time;
	} ctsc_cfg_type;

	localparam ctsc_time_type CTSC_TIME_ZERO = 24'h000000;
	localparam ctsc_time_type CTSC_TIME_ONE  = 24'h000001;
endpackage

//--- verilog/ctsc_camera_light_controller.sv
// camera trigger and light strobe timing machine
//
// How it works
// - next exposure never starts while the current exposure is running
// - readout phases of consecutive cycles never overlap
// - short next exposure: start waits readout minus next exposure after exposure end
// - long next exposure: next cycle may start right after exposure ends
// - four methods selectable: none, rate only, rate and width, external
// - none and external methods keep the machine idle, outputs low
// - one trigger pulse per cycle, leading edge starts exposure, and starts the cycle in late strobe mode only
// - rate only: the block paces the cycle rate and drives the same trigger width as rate and width
// - rate and width: trigger trailing edge ends exposure, width sets exposure
// - rate and width: rate and exposure both carried on one trigger line
// - strobe rises to light on and falls to light off
// - late strobe: strobe rises the offset after the trigger rises
// - early strobe: trigger rises the offset after the strobe rises
// - configure exposure to end after the light turns off
// - trigger width is exposure setting, strobe width is strobe setting
// - the later leading edge follows the earlier one by the offset
// - without overlap the next cycle waits for readout completion
`timescale 1ns/100ps
module ctsc_camera_light_controller
	import ctsc_pkg::*;
(
	// clock and reset
	input  wire logic              i_sys_clk,
	input  wire logic              i_sys_rst,
	// configuration
	input  wire ctsc_pkg::ctsc_cfg_type i_cfg,
	// cycle request and status
	input  wire logic              i_cycle_start,
	output logic                   o_cycle_taken,
	output logic                   o_next_allowed,
	output logic                   o_busy,
	// outputs to camera and light
	output logic                   o_camera_trigger,
	output logic                   o_light_strobe
);
	import ctsc_pkg::*;

	ctsc_state_type st_r, st_nxt;
	ctsc_time_type  cnt_r, cnt_nxt;     // time since cycle origin
	ctsc_time_type  guard_r, guard_nxt; // remaining wait before next allowed
	ctsc_time_type  exp_r, exp_nxt;     // exposure of running cycle
	logic           trig_r, trig_nxt;
	logic           strb_r, strb_nxt;
	logic           early_r, early_nxt;

	ctsc_time_type  t_trig_on, t_strb_on, t_trig_off, t_strb_off, t_end, wait_t;
	logic           ctl_on;

	// only the two grabber-driven methods run the machine
	assign ctl_on = (i_cfg.method == CTSC_RATE_ONLY) || (i_cfg.method == CTSC_RATE_WIDTH);

	always_comb begin
		// cycle origin is the earlier of the two leading edges
		t_trig_on  = early_r ? i_cfg.light_pulse_offset : CTSC_TIME_ZERO;
		t_strb_on  = early_r ? CTSC_TIME_ZERO : i_cfg.light_pulse_offset;
		t_trig_off = t_trig_on + exp_r;
		t_strb_off = t_strb_on + i_cfg.light_pulse_width;
		t_end      = (t_trig_off > t_strb_off) ? t_trig_off : t_strb_off;
		// wait after the later of trigger end and strobe end before another cycle may start
		if (!i_cfg.overlap_ok)
			wait_t = i_cfg.readout_time;
		else if (i_cfg.trigger_pulse_width < i_cfg.readout_time)
			wait_t = i_cfg.readout_time - i_cfg.trigger_pulse_width;
		else
			wait_t = CTSC_TIME_ZERO;
	end

	always_comb begin
		st_nxt      = st_r;
		cnt_nxt     = cnt_r;
		guard_nxt   = guard_r;
		exp_nxt     = exp_r;
		trig_nxt    = 1'b0;
		strb_nxt    = 1'b0;
		early_nxt   = early_r;
		o_cycle_taken = 1'b0;
		case (st_r)
			CTSC_IDLE: begin
				if (ctl_on && i_cycle_start) begin
					o_cycle_taken = 1'b1;
					exp_nxt   = i_cfg.trigger_pulse_width;
					early_nxt = i_cfg.early_light;
					cnt_nxt   = CTSC_TIME_ZERO;
					st_nxt    = CTSC_RUN;
					trig_nxt  = !i_cfg.early_light ||
						(i_cfg.light_pulse_offset == CTSC_TIME_ZERO);
					strb_nxt  = i_cfg.early_light ||
						(i_cfg.light_pulse_offset == CTSC_TIME_ZERO);
					if (i_cfg.trigger_pulse_width == CTSC_TIME_ZERO)
						trig_nxt = 1'b0;
					if (i_cfg.light_pulse_width == CTSC_TIME_ZERO)
						strb_nxt = 1'b0;
				end
			end
			CTSC_RUN: begin
				cnt_nxt  = cnt_r + CTSC_TIME_ONE;
				trig_nxt = (cnt_nxt >= t_trig_on) && (cnt_nxt < t_trig_off);
				strb_nxt = (cnt_nxt >= t_strb_on) && (cnt_nxt < t_strb_off);
				if (cnt_nxt >= t_end) begin
					trig_nxt  = 1'b0;
					strb_nxt  = 1'b0;
					guard_nxt = wait_t;
					st_nxt    = (wait_t == CTSC_TIME_ZERO) ? CTSC_IDLE : CTSC_GUARD;
				end
				if (!ctl_on) begin
					trig_nxt = 1'b0;
					strb_nxt = 1'b0;
					st_nxt   = CTSC_IDLE;
				end
			end
			CTSC_GUARD: begin
				guard_nxt = guard_r - CTSC_TIME_ONE;
				if (guard_r <= CTSC_TIME_ONE || !ctl_on)
					st_nxt = CTSC_IDLE;
			end
			default: begin
				st_nxt = CTSC_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_r      <= CTSC_IDLE;
			cnt_r     <= CTSC_TIME_ZERO;
			guard_r   <= CTSC_TIME_ZERO;
			exp_r     <= CTSC_TIME_ZERO;
			trig_r    <= 1'b0;
			strb_r    <= 1'b0;
			early_r   <= 1'b0;
		end else begin
			st_r      <= st_nxt;
			cnt_r     <= cnt_nxt;
			guard_r   <= guard_nxt;
			exp_r     <= exp_nxt;
			trig_r    <= trig_nxt;
			strb_r    <= strb_nxt;
			early_r   <= early_nxt;
		end
	end

	assign o_camera_trigger = trig_r;
	assign o_light_strobe   = strb_r;
	assign o_busy           = (st_r != CTSC_IDLE);
	assign o_next_allowed   = ctl_on && (st_r == CTSC_IDLE);

	// checker state: pulse lengths and time since exposure end
	ctsc_time_type  trig_len_r, trig_len_nxt;
	ctsc_time_type  strb_len_r, strb_len_nxt;
	ctsc_time_type  gap_r, gap_nxt;
	logic           seen_r, seen_nxt;

	always_comb begin
		trig_len_nxt = trig_r ? trig_len_r + CTSC_TIME_ONE : CTSC_TIME_ZERO;
		strb_len_nxt = strb_r ? strb_len_r + CTSC_TIME_ONE : CTSC_TIME_ZERO;
		gap_nxt      = gap_r;
		if (trig_r)
			gap_nxt = CTSC_TIME_ZERO;
		else if (gap_r != ~CTSC_TIME_ZERO)
			gap_nxt = gap_r + CTSC_TIME_ONE;
		// aborted or unmanaged cycles leave no exposure to guard
		seen_nxt = ctl_on && (seen_r || trig_r);
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			trig_len_r <= CTSC_TIME_ZERO;
			strb_len_r <= CTSC_TIME_ZERO;
			gap_r      <= CTSC_TIME_ZERO;
			seen_r     <= 1'b0;
		end else begin
			trig_len_r <= trig_len_nxt;
			strb_len_r <= strb_len_nxt;
			gap_r      <= gap_nxt;
			seen_r     <= seen_nxt;
		end
	end

	// assertions
	a_idle_no_trig: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		(!ctl_on && st_r == CTSC_IDLE) |=> !o_camera_trigger && !o_light_strobe)
		else $error("pulse produced while control method is off");
	a_take_only_idle: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		o_cycle_taken |-> (st_r == CTSC_IDLE) ##1 (st_r == CTSC_RUN))
		else $error("cycle taken while machine busy");
	a_late_trig_rise: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		(o_cycle_taken && !i_cfg.early_light && i_cfg.trigger_pulse_width != CTSC_TIME_ZERO)
		|=> o_camera_trigger)
		else $error("late strobe mode trigger did not rise");
	a_early_strb_rise: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		(o_cycle_taken && i_cfg.early_light && i_cfg.light_pulse_width != CTSC_TIME_ZERO)
		|=> o_light_strobe)
		else $error("early strobe mode strobe did not rise");
	a_trig_one_wide: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		(o_cycle_taken && !i_cfg.early_light && i_cfg.trigger_pulse_width == CTSC_TIME_ONE
		&& i_cfg.light_pulse_width <= CTSC_TIME_ONE && i_cfg.light_pulse_offset == CTSC_TIME_ZERO)
		|=> o_camera_trigger ##1 !o_camera_trigger)
		else $error("one cycle trigger width wrong");
	a_no_take_busy: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		o_busy |-> !o_cycle_taken)
		else $error("new cycle during running cycle");
	a_guard_block: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		(st_r == CTSC_GUARD) |-> !o_next_allowed && !o_camera_trigger)
		else $error("next cycle allowed during readout guard");
	a_reset_low: assert property (@(posedge i_sys_clk)
		$fell(i_sys_rst) |-> !o_camera_trigger && !o_light_strobe && !o_busy)
		else $error("outputs not idle after reset");
	a_trig_width_match: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		($fell(o_camera_trigger) && ctl_on) |-> trig_len_r == exp_r)
		else $error("trigger width differs from exposure setting");
	a_strb_width_match: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		($fell(o_light_strobe) && ctl_on) |-> strb_len_r == i_cfg.light_pulse_width)
		else $error("strobe width differs from strobe setting");
	a_offset_late: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		($rose(o_light_strobe) && !early_r) |-> cnt_r == i_cfg.light_pulse_offset)
		else $error("late strobe offset wrong");
	a_offset_early: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		($rose(o_camera_trigger) && early_r) |-> cnt_r == i_cfg.light_pulse_offset)
		else $error("early strobe trigger offset wrong");
	a_readout_gap: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		(o_cycle_taken && seen_r) |-> gap_r >= (!i_cfg.overlap_ok ? i_cfg.readout_time :
		((i_cfg.trigger_pulse_width < i_cfg.readout_time) ?
		(i_cfg.readout_time - i_cfg.trigger_pulse_width) : CTSC_TIME_ZERO)))
		else $error("next cycle started inside readout guard");
endmodule

//--- tb/ctsc_cam_model.sv
// camera and light model counting leading edges
`timescale 1ns/100ps
module ctsc_cam_model (
	// clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_sys_rst,
	// lines from the controller
	input  wire logic i_trig,
	input  wire logic i_strobe,
	// counts seen
	output int        o_cycles,
	output int        o_flashes
);
	logic t_r;
	logic s_r;
	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			t_r <= 1'b0;
			s_r <= 1'b0;
			o_cycles <= 0;
			o_flashes <= 0;
		end else begin
			t_r <= i_trig;
			s_r <= i_strobe;
			// trailing edges ignored
			if (i_trig && !t_r) o_cycles <= o_cycles + 1;
			if (i_strobe && !s_r) o_flashes <= o_flashes + 1;
		end
	end
endmodule

//--- tb/ctsc_camera_light_controller_bench.sv
// self-checking bench for the camera light controller
`timescale 1ns/100ps
module ctsc_camera_light_controller_bench;
	import ctsc_pkg::*;
	logic clk = 0, rst = 1, start = 0;
	ctsc_cfg_type cfg = '0;
	logic taken, allow, busy, trig, lit;
	int err_count = 0, n_compared = 0, cyc, fl;
	ctsc_cfg_type rows [7] = '{
		'{CTSC_RATE_ONLY, 1'b0, 1'b0, 24'h4, 24'h2, 24'h1, 24'h6},
		'{CTSC_RATE_WIDTH, 1'b0, 1'b1, 24'h5, 24'h3, 24'h2, 24'h8},
		'{CTSC_RATE_WIDTH, 1'b1, 1'b1, 24'h6, 24'h2, 24'h3, 24'h4},
		'{CTSC_NO_CONTROL, 1'b0, 1'b0, 24'h4, 24'h2, 24'h1, 24'h6},
		'{CTSC_EXTERNAL, 1'b0, 1'b0, 24'h4, 24'h2, 24'h1, 24'h6},
		'{CTSC_RATE_WIDTH, 1'b0, 1'b0, 24'h1, 24'h1, 24'h0, 24'h3},
		'{CTSC_RATE_ONLY, 1'b1, 1'b1, 24'h3, 24'h2, 24'h0, 24'h2}};
	logic [6:0] ok_row = 7'h67;
	ctsc_camera_light_controller DUT (.i_sys_clk(clk), .i_sys_rst(rst), .i_cfg(cfg),
		.i_cycle_start(start), .o_cycle_taken(taken), .o_next_allowed(allow),
		.o_busy(busy), .o_camera_trigger(trig), .o_light_strobe(lit));
	ctsc_cam_model cam (.i_sys_clk(clk), .i_sys_rst(rst), .i_trig(trig),
		.i_strobe(lit), .o_cycles(cyc), .o_flashes(fl));
	initial forever #25 clk = ~clk;
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t got %0h want %0h", $time, seen, exp);
		end
	endtask
	task stop_test;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task run(input ctsc_cfg_type c, input logic ok);
		int tf, tn, sf, sn, al, e, g;
		{tf, tn, sf, sn, al} = '0;
		@(posedge clk);
		cfg <= c;
		start <= 1'b1;
		@(negedge clk);
		chk(taken, ok);
		@(posedge clk);
		start <= 1'b0;
		for (int k = 1; k < 80; k++) begin
			@(negedge clk);
			if (trig) begin tn++; if (tf == 0) tf = k; end
			if (lit) begin sn++; if (sf == 0) sf = k; end
			if (allow && al == 0 && k > 1) al = k;
		end
		if (ok) begin
			chk(tn, c.trigger_pulse_width);
			chk(sn, c.light_pulse_width);
			chk(tf, c.early_light ? 1 + c.light_pulse_offset : 1);
			chk(sf, c.early_light ? 1 : 1 + c.light_pulse_offset);
			e = (tf + tn > sf + sn) ? tf + tn - 1 : sf + sn - 1;
			g = !c.overlap_ok ? c.readout_time : (c.trigger_pulse_width < c.readout_time ?
				c.readout_time - c.trigger_pulse_width : 0);
			chk(al >= e + g && al <= e + g + 3, 1);
		end else chk(tn + sn, 0);
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		stop_test;
	end
	initial begin
		repeat (5) @(posedge clk);
		chk({trig, lit, busy}, 0);
		rst <= 1'b0;
		for (int r = 0; r < 7; r++) run(rows[r], ok_row[r]);
		chk(cyc, 5);
		chk(fl, 5);
		@(posedge clk);
		cfg <= rows[0];
		start <= 1'b1;
		@(negedge clk);
		@(negedge clk);
		chk(taken, 0);
		@(posedge clk);
		start <= 1'b0;
		cfg.method <= CTSC_EXTERNAL;
		@(negedge clk);
		@(negedge clk);
		chk({trig, lit, busy}, 0);
		@(posedge clk);
		cfg <= rows[1];
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		@(posedge clk);
		rst <= 1'b1;
		@(negedge clk);
		chk({trig, lit, busy}, 0);
		@(posedge clk);
		rst <= 1'b0;
		run(rows[1], 1'b1);
		stop_test;
	end
endmodule
